// File: ppo_map.vh
// Register map, field positions and reset values of the port block
`ifndef PPO_MAP_VH
`define PPO_MAP_VH
`define PPO_ADR_D_LVL   8'h10
`define PPO_ADR_D_DIR   8'h11
`define PPO_ADR_D_DAT   8'h12
`define PPO_ADR_B_LVL   8'h16
`define PPO_ADR_B_DIR   8'h17
`define PPO_ADR_B_DAT   8'h18
`define PPO_ADR_A_LVL   8'h19
`define PPO_ADR_A_DIR   8'h1A
`define PPO_ADR_A_DAT   8'h1B
`define PPO_ADR_CTRL    8'h35
`define PPO_PU_OFF_BIT  7
`define PPO_MASK_A      8'h07
`define PPO_MASK_B      8'hFF
`define PPO_MASK_D      8'h7F
`define PPO_RST_VAL     8'h00
`endif

// File: ppo_sync.v
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ns
`default_nettype none
module ppo_sync (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        reset_n,
  // Raw and synchronised levels
  input  wire [17:0] async_in,
  output reg  [17:0] sync_out
);
  reg [17:0] meta_r;
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      meta_r   <= 18'h00000;
      sync_out <= 18'h00000;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// File: ppo_port.v
// Port A/B/D registers, pin drivers and port D alternate-function overrides
`timescale 1ns/1ns
`default_nettype none
`include "ppo_map.vh"
module ppo_port (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       reset_n,
  // Register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // Pin inputs
  input  wire [2:0] pin_a_in,
  input  wire [7:0] pin_b_in,
  input  wire [6:0] pin_d_in,
  // Pin drivers
  output reg  [2:0] pin_a_out,
  output reg  [2:0] pin_a_oe,
  output reg  [2:0] pin_a_pullup,
  output reg  [7:0] pin_b_out,
  output reg  [7:0] pin_b_oe,
  output reg  [7:0] pin_b_pullup,
  output reg  [6:0] pin_d_out,
  output reg  [6:0] pin_d_oe,
  output reg  [6:0] pin_d_pullup,
  output reg  [6:0] pin_d_input_en,
  // Peripheral overrides
  input  wire       capture_enable,
  input  wire       timer1_ext_clock_enable,
  input  wire       timer0_ext_clock_enable,
  input  wire       external_irq_zero_enable,
  input  wire       external_irq_one_enable,
  input  wire       usart_transfer_clock_in_enable,
  input  wire [6:0] pin_change_mask,
  input  wire       timer1_cmp_b_override_enable,
  input  wire       timer1_cmp_b_value,
  input  wire       xfer_clock_out_override_enable,
  input  wire       xfer_clock_out_value,
  input  wire       uart_tx_enable,
  input  wire       uart_tx_value,
  input  wire       uart_rx_enable,
  // Peripheral inputs and control register copy
  output reg        capture_input_pin,
  output reg  [6:0] pin_change_level,
  output reg        timer0_ext_clock_in,
  output reg        timer1_ext_clock_in,
  output reg        external_irq_zero,
  output reg        external_irq_one,
  output reg        usart_transfer_clock,
  output reg        uart_rx_in,
  output reg  [7:0] mcu_control
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  reg  [2:0] data_a_r;
  reg  [2:0] dir_a_r;
  reg  [7:0] data_b_r;
  reg  [7:0] dir_b_r;
  reg  [6:0] data_d_r;
  reg  [6:0] dir_d_r;
  reg  [7:0] ctrl_r;
  wire [17:0] pins_sync;
  wire [2:0] lvl_a;
  wire [7:0] lvl_b;
  wire [6:0] lvl_d;
  wire       pu_off;

  ppo_sync u_sync (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .async_in ({pin_d_in, pin_b_in, pin_a_in}),
    .sync_out (pins_sync)
  );

  assign lvl_a = pins_sync[2:0];
  assign lvl_b = pins_sync[10:3];
  assign lvl_d = pins_sync[17:11];
  assign pu_off = ctrl_r[`PPO_PU_OFF_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  wire wr_ctrl  = reg_wr && (reg_addr == `PPO_ADR_CTRL);
  wire wr_pa    = reg_wr && (reg_addr == `PPO_ADR_A_DAT);
  wire wr_da    = reg_wr && (reg_addr == `PPO_ADR_A_DIR);
  wire wr_ia    = reg_wr && (reg_addr == `PPO_ADR_A_LVL);
  wire wr_pb    = reg_wr && (reg_addr == `PPO_ADR_B_DAT);
  wire wr_db    = reg_wr && (reg_addr == `PPO_ADR_B_DIR);
  wire wr_ib    = reg_wr && (reg_addr == `PPO_ADR_B_LVL);
  wire wr_pd    = reg_wr && (reg_addr == `PPO_ADR_D_DAT);
  wire wr_dd    = reg_wr && (reg_addr == `PPO_ADR_D_DIR);
  wire wr_id    = reg_wr && (reg_addr == `PPO_ADR_D_LVL);

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl_r <= `PPO_RST_VAL;
    end else if (wr_ctrl) begin
      ctrl_r <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port A registers

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      data_a_r <= 3'h0;
      dir_a_r  <= 3'h0;
    end else begin
      if (wr_pa) begin
        data_a_r <= reg_wdata[2:0];
      end else if (wr_ia) begin
        data_a_r <= data_a_r ^ reg_wdata[2:0];
      end
      if (wr_da) begin
        dir_a_r <= reg_wdata[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port B registers

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      data_b_r <= `PPO_RST_VAL;
      dir_b_r  <= `PPO_RST_VAL;
    end else begin
      if (wr_pb) begin
        data_b_r <= reg_wdata;
      end else if (wr_ib) begin
        data_b_r <= data_b_r ^ reg_wdata;
      end
      if (wr_db) begin
        dir_b_r <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port D registers

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      data_d_r <= 7'h00;
      dir_d_r  <= 7'h00;
    end else begin
      if (wr_pd) begin
        data_d_r <= reg_wdata[6:0];
      end else if (wr_id) begin
        data_d_r <= data_d_r ^ reg_wdata[6:0];
      end
      if (wr_dd) begin
        dir_d_r <= reg_wdata[6:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads

  reg [7:0] rdata_nxt;
  always @* begin
    case (reg_addr)
      `PPO_ADR_CTRL:  rdata_nxt = ctrl_r;
      `PPO_ADR_A_DAT: rdata_nxt = {5'h00, data_a_r};
      `PPO_ADR_A_DIR: rdata_nxt = {5'h00, dir_a_r};
      `PPO_ADR_A_LVL: rdata_nxt = {5'h00, lvl_a};
      `PPO_ADR_B_DAT: rdata_nxt = data_b_r;
      `PPO_ADR_B_DIR: rdata_nxt = dir_b_r;
      `PPO_ADR_B_LVL: rdata_nxt = lvl_b;
      `PPO_ADR_D_DAT: rdata_nxt = {1'b0, data_d_r};
      `PPO_ADR_D_DIR: rdata_nxt = {1'b0, dir_d_r};
      `PPO_ADR_D_LVL: rdata_nxt = {1'b0, lvl_d};
      default:        rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port D override signals

  reg [6:0] pu_oe;
  reg [6:0] pu_ov;
  reg [6:0] dd_oe;
  reg [6:0] dd_ov;
  reg [6:0] pv_oe;
  reg [6:0] pv_ov;
  reg [6:0] die_oe;
  reg [6:0] die_ov;

  always @* begin
    pu_oe  = 7'h00;
    pu_ov  = 7'h00;
    dd_oe  = 7'h00;
    dd_ov  = 7'h00;
    pv_oe  = 7'h00;
    pv_ov  = 7'h00;
    die_oe = pin_change_mask;
    die_ov = pin_change_mask;
    die_oe[6] = capture_enable | pin_change_mask[6];
    pv_oe[5]  = timer1_cmp_b_override_enable;
    pv_ov[5]  = timer1_cmp_b_value;
    die_oe[5] = timer1_ext_clock_enable | pin_change_mask[5];
    die_oe[4] = timer0_ext_clock_enable | pin_change_mask[4];
    die_oe[3] = external_irq_one_enable | pin_change_mask[3];
    die_oe[2] = external_irq_zero_enable | usart_transfer_clock_in_enable |
                pin_change_mask[2];
    pv_oe[2]  = xfer_clock_out_override_enable;
    pv_ov[2]  = xfer_clock_out_value;
    pu_oe[1]  = uart_tx_enable;
    dd_oe[1]  = uart_tx_enable;
    dd_ov[1]  = 1'b1;
    pv_oe[1]  = uart_tx_enable;
    pv_ov[1]  = uart_tx_value;
    pu_oe[0]  = uart_rx_enable;
    pu_ov[0]  = data_d_r[0] & ~pu_off;
    dd_oe[0]  = uart_rx_enable;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers

  wire [6:0] d_dir;
  wire [6:0] d_val;
  wire [6:0] d_pu;
  wire [6:0] d_ien;
  genvar     gi;

  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_pin_d
      assign d_dir[gi] = dd_oe[gi] ? dd_ov[gi] : dir_d_r[gi];
      assign d_val[gi] = pv_oe[gi] ? pv_ov[gi] : data_d_r[gi];
      assign d_pu[gi]  = pu_oe[gi] ? pu_ov[gi] : ~dir_d_r[gi] & data_d_r[gi] & ~pu_off;
      assign d_ien[gi] = ~die_oe[gi] | die_ov[gi];
    end
  endgenerate

  wire [2:0] a_pu;
  wire [7:0] b_pu;

  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_pu_a
      assign a_pu[gi] = ~dir_a_r[gi] & data_a_r[gi] & ~pu_off;
    end
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pu_b
      assign b_pu[gi] = ~dir_b_r[gi] & data_b_r[gi] & ~pu_off;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Registered pin drivers

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      pin_a_out      <= 3'h0;
      pin_a_oe       <= 3'h0;
      pin_a_pullup   <= 3'h0;
      pin_b_out      <= 8'h00;
      pin_b_oe       <= 8'h00;
      pin_b_pullup   <= 8'h00;
      pin_d_out      <= 7'h00;
      pin_d_oe       <= 7'h00;
      pin_d_pullup   <= 7'h00;
      pin_d_input_en <= 7'h7F;
      mcu_control    <= 8'h00;
    end else begin
      pin_a_out      <= data_a_r;
      pin_a_oe       <= dir_a_r;
      pin_a_pullup   <= a_pu;
      pin_b_out      <= data_b_r;
      pin_b_oe       <= dir_b_r;
      pin_b_pullup   <= b_pu;
      pin_d_out      <= d_val;
      pin_d_oe       <= d_dir;
      pin_d_pullup   <= d_pu & ~d_dir;
      pin_d_input_en <= d_ien;
      mcu_control    <= ctrl_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alternate-function inputs

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      capture_input_pin    <= 1'b0;
      pin_change_level     <= 7'h00;
      timer0_ext_clock_in  <= 1'b0;
      timer1_ext_clock_in  <= 1'b0;
      external_irq_zero    <= 1'b0;
      external_irq_one     <= 1'b0;
      usart_transfer_clock <= 1'b0;
      uart_rx_in           <= 1'b0;
    end else begin
      capture_input_pin    <= lvl_d[6];
      pin_change_level     <= lvl_d & d_ien;
      timer0_ext_clock_in  <= lvl_d[4];
      timer1_ext_clock_in  <= lvl_d[5];
      external_irq_zero    <= lvl_d[2];
      external_irq_one     <= lvl_d[3];
      usart_transfer_clock <= lvl_d[2];
      uart_rx_in           <= lvl_d[0];
    end
  end

endmodule
`default_nettype wire

// File: ppo_pin_env.sv
// Pin-side model: device drivers, pull-ups and external sources
`timescale 1ns/1ns
`default_nettype none
module ppo_pin_env #(parameter int W = 8) (
  // Clock
  input  wire logic         clk_sys,
  // Device side
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] pu,
  // External source
  input  wire logic [W-1:0] ext_val,
  input  wire logic [W-1:0] ext_en,
  // Pin level
  output var  logic [W-1:0] lvl
);
  logic [W-1:0] flt_r = '0;
  always @(posedge clk_sys) flt_r <= ~flt_r;
  // Driver wins, then source, then pull-up; an open pin wanders
  always_comb
    for (int i = 0; i < W; i++)
      lvl[i] = oe[i] ? out[i] : ext_en[i] ? ext_val[i] : pu[i] ? 1'b1 : flt_r[i];
endmodule
`default_nettype wire

// File: ppo_port_assertions.sv
// Concurrent checks on the port block
`timescale 1ns/1ns
`default_nettype none
module ppo_port_assertions (
  // Clock, reset and register port
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic [7:0] mcu_control,
  // Pin drivers
  input wire logic [7:0] pin_b_oe,
  input wire logic [7:0] pin_b_pullup,
  input wire logic [6:0] pin_d_out,
  input wire logic [6:0] pin_d_oe,
  input wire logic [6:0] pin_d_input_en,
  // Overrides
  input wire logic       capture_enable,
  input wire logic [6:0] pin_change_mask,
  input wire logic       timer1_cmp_b_override_enable,
  input wire logic       timer1_cmp_b_value,
  input wire logic       xfer_clock_out_override_enable,
  input wire logic       xfer_clock_out_value,
  input wire logic       uart_tx_enable,
  input wire logic       uart_tx_value,
  input wire logic       uart_rx_enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  // Single write to one address
  sequence s_wr(a);
    reg_wr && reg_addr == a ##1 !(reg_wr && reg_addr == a);
  endsequence
  property p_dir_b; s_wr(8'h17) |=> pin_b_oe == $past(reg_wdata, 2); endproperty
  a_dir_b: assert property (p_dir_b) else $error("port B drive mismatch");
  property p_dir_d; s_wr(8'h11) |=> pin_d_oe[6:2] == $past(reg_wdata[6:2], 2); endproperty
  a_dir_d: assert property (p_dir_d) else $error("port D drive mismatch");
  property p_pu_off; mcu_control[7] [*2] |-> pin_b_pullup == 8'h00; endproperty
  a_pu_off: assert property (p_pu_off) else $error("pull-up on while disabled");
  property p_tx; uart_tx_enable [*2] |-> pin_d_oe[1] && pin_d_out[1] == $past(uart_tx_value);
  endproperty
  a_tx: assert property (p_tx) else $error("transmit pin not driven");
  property p_rx; uart_rx_enable [*2] |-> !pin_d_oe[0]; endproperty
  a_rx: assert property (p_rx) else $error("receive pin driven");
  property p_cap;
    (capture_enable || pin_change_mask[6]) [*2] |-> pin_d_input_en[6] == $past(pin_change_mask[6]);
  endproperty
  a_cap: assert property (p_cap) else $error("capture pin input enable wrong");
  property p_cmpb;
    timer1_cmp_b_override_enable [*2] |-> pin_d_out[5] == $past(timer1_cmp_b_value);
  endproperty
  a_cmpb: assert property (p_cmpb) else $error("compare B value wrong");
  property p_xclk;
    xfer_clock_out_override_enable [*2] |-> pin_d_out[2] == $past(xfer_clock_out_value);
  endproperty
  a_xclk: assert property (p_xclk) else $error("transfer clock value wrong");
endmodule
bind ppo_port ppo_port_assertions u_chk (.*);
`default_nettype wire

// File: ppo_port_tb.sv
// Self-checking bench for the port block
`timescale 1ns/1ns
`default_nettype none
module ppo_port_tb;
  logic        clk_sys, reset_n, reg_wr, reg_rd;
  logic        rd_d = 1'b0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, mcu_control, d, v, e;
  logic [2:0]  pin_a_in, pin_a_out, pin_a_oe, pin_a_pullup;
  logic [7:0]  pin_b_in, pin_b_out, pin_b_oe, pin_b_pullup;
  logic [6:0]  pin_d_in, pin_d_out, pin_d_oe, pin_d_pullup, pin_d_input_en;
  logic [6:0]  pin_change_mask, pin_change_level, per_in;
  logic [12:0] ov;
  logic [7:0]  ev[3], en[3], exp_q[$];
  logic [7:0]  pb[3] = '{8'h19, 8'h16, 8'h10};
  logic [7:0]  pm[3] = '{8'h07, 8'hFF, 8'h7F};
  int          n_mismatch = 0;
  int          check_count = 0;
  ppo_port dut (.*, .capture_enable(ov[12]), .timer1_ext_clock_enable(ov[11]),
    .timer0_ext_clock_enable(ov[10]), .external_irq_zero_enable(ov[9]),
    .external_irq_one_enable(ov[8]), .usart_transfer_clock_in_enable(ov[7]),
    .timer1_cmp_b_override_enable(ov[6]), .timer1_cmp_b_value(ov[5]),
    .xfer_clock_out_override_enable(ov[4]), .xfer_clock_out_value(ov[3]),
    .uart_tx_enable(ov[2]), .uart_tx_value(ov[1]), .uart_rx_enable(ov[0]),
    .capture_input_pin(per_in[6]), .timer0_ext_clock_in(per_in[5]),
    .timer1_ext_clock_in(per_in[4]), .external_irq_zero(per_in[3]),
    .external_irq_one(per_in[2]), .usart_transfer_clock(per_in[1]), .uart_rx_in(per_in[0]));
  ppo_pin_env #(.W(3)) u_pa (.clk_sys(clk_sys), .out(pin_a_out), .oe(pin_a_oe),
    .pu(pin_a_pullup), .ext_val(ev[0][2:0]), .ext_en(en[0][2:0]), .lvl(pin_a_in));
  ppo_pin_env #(.W(8)) u_pb (.clk_sys(clk_sys), .out(pin_b_out), .oe(pin_b_oe),
    .pu(pin_b_pullup), .ext_val(ev[1]), .ext_en(en[1]), .lvl(pin_b_in));
  ppo_pin_env #(.W(7)) u_pd (.clk_sys(clk_sys), .out(pin_d_out), .oe(pin_d_oe),
    .pu(pin_d_pullup), .ext_val(ev[2][6:0]), .ext_en(en[2][6:0]), .lvl(pin_d_in));
  ////////////////////////////////////////
  task automatic bus(input logic w, r, input logic [7:0] a, dat, x);
    if (r) exp_q.push_back(x);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= dat;
    @(posedge clk_sys);
  endtask
  task automatic nop(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
  endtask
  task automatic chk(input logic [7:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Read data stands one cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_d) chk(reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
  end
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    n_mismatch++;
    stop_test;
  end
  ////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    {reg_wr, reg_rd, reg_addr, reg_wdata, pin_change_mask, ov} = '0;
    ev = '{default: 8'h00};
    en = '{default: 8'h00};
    void'($urandom(46));
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int j = 0; j < 3; j++)
      for (int k = 1; k < 3; k++)
        bus(1'b0, 1'b1, 8'(pb[j] + k), 8'h00, 8'h00);
    bus(1'b0, 1'b1, 8'h35, 8'h00, 8'h00);
    bus(1'b0, 1'b1, 8'h13, 8'h00, 8'h00);
    $display("reset values done");
    for (int j = 0; j < 3; j++)
      for (int k = 1; k < 3; k++) begin
        v = 8'($urandom);
        bus(1'b1, 1'b0, 8'(pb[j] + k), v, 8'h00);
        bus(1'b0, 1'b1, 8'(pb[j] + k), 8'h00, v & pm[j]);
      end
    v = 8'($urandom) | 8'h80;
    bus(1'b1, 1'b0, 8'h35, v, 8'h00);
    bus(1'b0, 1'b1, 8'h35, 8'h00, v);
    nop(3);
    bus(1'b1, 1'b0, 8'h35, 8'h00, 8'h00);
    $display("register access done");
    repeat (6)
      for (int j = 0; j < 3; j++) begin
        d = 8'($urandom) & pm[j];
        v = 8'($urandom) & pm[j];
        bus(1'b1, 1'b0, 8'(pb[j] + 1), d, 8'h00);
        bus(1'b1, 1'b0, 8'(pb[j] + 2), v, 8'h00);
        en[j] <= ~d & ~v;
        ev[j] <= 8'($urandom);
        nop(5);
        bus(1'b0, 1'b1, pb[j], 8'h00, (v | ~d & ev[j]) & pm[j]);
        e = 8'($urandom);
        bus(1'b1, 1'b0, pb[j], e, 8'h00);
        bus(1'b0, 1'b1, 8'(pb[j] + 2), 8'h00, (v ^ e) & pm[j]);
      end
    $display("pin drive done");
    bus(1'b1, 1'b0, 8'h11, 8'h25, 8'h00);
    bus(1'b1, 1'b0, 8'h12, 8'h01, 8'h00);
    repeat (6) begin
      v = 8'($urandom);
      ov <= {v[5:0], 1'b1, v[2], 1'b1, v[1], 1'b1, v[0], 1'b1};
      pin_change_mask <= 7'($urandom);
      en[2] <= 8'h59;
      ev[2] <= 8'($urandom);
      nop(5);
      d = ev[2] & 8'h59 | {v[2], 2'b00, v[1], v[0], 1'b0};
      e = {1'b0, v[5:3], v[1], v[2] | v[0], 2'b00};
      bus(1'b0, 1'b1, 8'h10, 8'h00, d);
      chk({1'b0, pin_change_level}, d & ({1'b0, pin_change_mask} | ~e));
      chk({1'b0, per_in}, {1'b0, d[6], d[4], d[5], d[2], d[3], d[2], d[0]});
    end
    ov <= '0;
    nop(3);
    $display("overrides done");
    stop_test;
  end
endmodule
`default_nettype wire
